// ### hdl/acl_pkg.sv
// Behaviour
// - Busy lasts between 2 and 9 configuration clock periods per byte.
// - Busy shows whenever the converter cannot take another byte.
// - A byte into an empty converter gets the shortest busy time.
// - A byte waiting behind a byte still shifting gets the longest busy time.
// - A new byte starts shifting only after the previous byte finishes.
// - The memory-clear flag is only ever pulled low, else released.
// - Master clock period is 640-2000 ns slow or 80-250 ns fast.
package acl_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int BUSY_MIN_PERIODS = 2;
	localparam int BUSY_MAX_PERIODS = 9;
	localparam int BUSY_SHORT_SLACK = 1;
	localparam int CONFIG_CLOCK_SLOW_MIN_NS = 640;
	localparam int CONFIG_CLOCK_SLOW_MAX_NS = 2000;
	localparam int CONFIG_CLOCK_FAST_MIN_NS = 80;
	localparam int CONFIG_CLOCK_FAST_MAX_NS = 250;
	localparam int CONFIG_CLOCK_IN_PERIOD_MIN_NS = 100;
	localparam int CONFIG_CLOCK_IN_DELAY_MIN_US = 4;
	localparam int POR_M0_HIGH_MIN_MS = 10;
	localparam int POR_M0_LOW_MIN_MS = 40;
	localparam int NS_PER_MS = 1000000;

	function automatic int ceilCycles(input int ns);
		ceilCycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

	localparam int CONFIG_CLOCK_SLOW_HALF = ceilCycles(CONFIG_CLOCK_SLOW_MIN_NS) / 2;
	localparam int CONFIG_CLOCK_FAST_HALF = ceilCycles(CONFIG_CLOCK_FAST_MIN_NS) / 2;
	localparam int POR_HIGH_CYCLES = ceilCycles(POR_M0_HIGH_MIN_MS * NS_PER_MS);
	localparam int POR_LOW_CYCLES = ceilCycles(POR_M0_LOW_MIN_MS * NS_PER_MS);

	// ****************************************
	// widths and fields
	// ****************************************
	localparam int BYTE_BITS = 8;
	localparam int POR_CNT_W = 24;
	localparam int GEN_CNT_W = 8;
	localparam int BUSY_CNT_W = 4;
	localparam int BIT_CNT_W = 4;
	localparam int STATUS_READY_BIT = 7;
	localparam int SYNC_W = 16;
	localparam int SY_DATA = 0;
	localparam int SY_WSN = 8;
	localparam int SY_RSN = 9;
	localparam int SY_CS0N = 10;
	localparam int SY_CS1 = 11;
	localparam int SY_INIT = 12;
	localparam int SY_MASTER = 13;
	localparam int SY_FAST = 14;
	localparam int SY_M0 = 15;

	typedef enum logic [1:0] {
		PH_STRAP,
		PH_CLEAR,
		PH_WAIT_CHAIN,
		PH_LOAD
	} acl_phase_e;

endpackage

// ### hdl/acl_pair_buffer.sv
`timescale 1ns/1ps
module acl_pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [CW-1:0] count_q, count_d;
	logic [WIDTH-1:0] outData_q, outData_d;
	logic push, pop;

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		nextPtr = (p == LAST) ? '0 : p + PW'(1);
	endfunction

	assign inReady = count_q != CW'(DEPTH);
	assign outValid = count_q != '0;
	assign outData = outData_q;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb
	begin
		mem_d = mem_q;
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		count_d = count_q;
		if (push)
		begin
			mem_d[wrPtr_q] = inData;
			wrPtr_d = nextPtr(wrPtr_q);
		end
		if (pop)
			rdPtr_d = nextPtr(rdPtr_q);
		if (push && !pop)
			count_d = count_q + CW'(1);
		else if (pop && !push)
			count_d = count_q - CW'(1);
		// head word registered so it stands while waiting
		outData_d = mem_d[rdPtr_d];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
			outData_q <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end
		else
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			count_q <= count_d;
			outData_q <= outData_d;
			mem_q <= mem_d;
		end
	end
endmodule

// ### hdl/acl_async_loader.sv
`timescale 1ns/1ps
module acl_async_loader #(
	parameter int PorHighCycles = acl_pkg::POR_HIGH_CYCLES,
	parameter int PorLowCycles = acl_pkg::POR_LOW_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic configClk,
	input wire logic writeStrobeN,
	input wire logic readStrobeN,
	input wire logic chipSelectLowN,
	input wire logic chipSelectHigh,
	input wire logic [acl_pkg::BYTE_BITS-1:0] dataIn,
	output logic [acl_pkg::BYTE_BITS-1:0] dataOut,
	output logic dataOe,
	output logic readyBusy,
	input wire logic initIn,
	output logic initOut,
	output logic initOe,
	input wire logic masterMode,
	input wire logic fastRate,
	input wire logic modePinZero,
	output logic configClockOut,
	output logic configClockOe,
	output logic serialOut,
	output logic serialValid
);
	localparam int BW = acl_pkg::BYTE_BITS;
	localparam int GW = acl_pkg::GEN_CNT_W;
	localparam int CW = acl_pkg::BUSY_CNT_W;
	localparam int NW = acl_pkg::BIT_CNT_W;
	localparam int PW = acl_pkg::POR_CNT_W;

	// ****************************************
	// pin synchronisers, system clock
	// ****************************************
	logic [acl_pkg::SYNC_W-1:0] syncA_q, syncB_q, pins;
	assign pins = {modePinZero, fastRate, masterMode, initIn, chipSelectHigh,
		chipSelectLowN, readStrobeN, writeStrobeN, dataIn};

	logic [BW-1:0] sData;
	logic sWsN, sRsN, sCs0N, sCs1, sInit, sMaster, sFast, sM0;
	assign sData = syncB_q[acl_pkg::SY_DATA +: BW];
	assign sWsN = syncB_q[acl_pkg::SY_WSN];
	assign sRsN = syncB_q[acl_pkg::SY_RSN];
	assign sCs0N = syncB_q[acl_pkg::SY_CS0N];
	assign sCs1 = syncB_q[acl_pkg::SY_CS1];
	assign sInit = syncB_q[acl_pkg::SY_INIT];
	assign sMaster = syncB_q[acl_pkg::SY_MASTER];
	assign sFast = syncB_q[acl_pkg::SY_FAST];
	assign sM0 = syncB_q[acl_pkg::SY_M0];

	// ****************************************
	// system clock state
	// ****************************************
	acl_pkg::acl_phase_e phase_q, phase_d;
	logic [PW-1:0] porCnt_q, porCnt_d;
	logic wrPrev_q, wrPrev_d;
	logic [BW-1:0] capData_q, capData_d, pendData_q, pendData_d, hold_q, hold_d;
	logic pendValid_q, pendValid_d;
	logic busy_q, busy_d;
	logic [CW-1:0] busyCnt_q, busyCnt_d;
	logic tickS1_q, tickS2_q, tickS3_q, tick_q, linkIdle_q, reqSeen_q;
	logic ackS1_q, ackS2_q, idleS1_q, idleS2_q;
	logic reqTog_q, reqTog_d;
	logic [GW-1:0] genCnt_q, genCnt_d;
	logic genClk_q, genClk_d, genOe_q, genOe_d;
	logic [BW-1:0] rdData_q, rdData_d;
	logic rdOe_q, rdOe_d, initLow_q, initLow_d;

	logic wrAct, rdAct, commit, periodPulse, reqBusy, sendNow, bufInReady, bufOutValid;
	logic [BW-1:0] bufOutData;
	logic [GW-1:0] half;

	assign wrAct = phase_q == acl_pkg::PH_LOAD && !sCs0N && sCs1 && !sWsN && sRsN;
	assign rdAct = phase_q == acl_pkg::PH_LOAD && !sCs0N && sCs1 && !sRsN && sWsN;
	assign commit = wrPrev_q && !wrAct;
	assign periodPulse = tickS2_q ^ tickS3_q;
	assign reqBusy = reqTog_q != ackS2_q;
	assign sendNow = bufOutValid && !reqBusy;
	assign half = sFast ? GW'(acl_pkg::CONFIG_CLOCK_FAST_HALF) : GW'(acl_pkg::CONFIG_CLOCK_SLOW_HALF);

	acl_pair_buffer #(
		.WIDTH(BW),
		.DEPTH(2)
	) u_buf (
		.clk(mclk),
		.rst(rst),
		.inValid(pendValid_q),
		.inReady(bufInReady),
		.inData(pendData_q),
		.outValid(bufOutValid),
		.outReady(sendNow),
		.outData(bufOutData)
	);

	always_comb
	begin
		phase_d = phase_q;
		porCnt_d = porCnt_q;
		initLow_d = 1'b0;
		unique case (phase_q)
			acl_pkg::PH_STRAP:
			begin
				// strap caught once synchronised, after reset release
				porCnt_d = sM0 ? PW'(PorHighCycles) : PW'(PorLowCycles);
				initLow_d = 1'b1;
				phase_d = acl_pkg::PH_CLEAR;
			end
			acl_pkg::PH_CLEAR:
			begin
				initLow_d = 1'b1;
				porCnt_d = porCnt_q - PW'(1);
				if (porCnt_q <= PW'(1))
				begin
					initLow_d = 1'b0;
					phase_d = acl_pkg::PH_WAIT_CHAIN;
				end
			end
			acl_pkg::PH_WAIT_CHAIN:
				if (sInit)
					phase_d = acl_pkg::PH_LOAD;
			acl_pkg::PH_LOAD: ;
		endcase

		// byte taken from the synchronised bus while the write is open
		wrPrev_d = wrAct;
		capData_d = wrAct ? sData : capData_q;
		pendData_d = pendData_q;
		pendValid_d = pendValid_q;
		if (pendValid_q && bufInReady)
			pendValid_d = 1'b0;
		if (commit)
		begin
			pendValid_d = 1'b1;
			pendData_d = capData_q;
		end

		hold_d = hold_q;
		reqTog_d = reqTog_q;
		if (sendNow)
		begin
			hold_d = bufOutData;
			reqTog_d = !reqTog_q;
		end

		busy_d = busy_q;
		busyCnt_d = busyCnt_q;
		if (commit)
		begin
			busy_d = 1'b1;
			busyCnt_d = '0;
		end
		else if (busy_q && phase_q == acl_pkg::PH_LOAD)
		begin
			if (periodPulse && busyCnt_q != '1)
				busyCnt_d = busyCnt_q + CW'(1);
			// release only once the byte sits in the shifter
			if (busyCnt_q >= CW'(acl_pkg::BUSY_MIN_PERIODS) && !pendValid_q
				&& !bufOutValid && !reqBusy)
				busy_d = 1'b0;
		end

		genOe_d = sMaster && phase_q == acl_pkg::PH_LOAD;
		genCnt_d = genCnt_q;
		genClk_d = genClk_q;
		if (!genOe_q)
		begin
			genCnt_d = '0;
			genClk_d = 1'b0;
		end
		else if (genCnt_q + GW'(1) >= half)
		begin
			genCnt_d = '0;
			genClk_d = !genClk_q;
		end
		else
			genCnt_d = genCnt_q + GW'(1);

		rdOe_d = rdAct;
		rdData_d = '0;
		rdData_d[acl_pkg::STATUS_READY_BIT] = !busy_q;
	end

	always_ff @(posedge mclk)
	begin
		syncA_q <= pins;
		syncB_q <= syncA_q;
		tickS1_q <= tick_q;
		tickS2_q <= tickS1_q;
		tickS3_q <= tickS2_q;
		ackS1_q <= reqSeen_q;
		ackS2_q <= ackS1_q;
		idleS1_q <= linkIdle_q;
		idleS2_q <= idleS1_q;
		if (rst)
		begin
			phase_q <= acl_pkg::PH_STRAP;
			porCnt_q <= '0;
			wrPrev_q <= 1'b0;
			capData_q <= '0;
			pendData_q <= '0;
			pendValid_q <= 1'b0;
			hold_q <= '0;
			reqTog_q <= 1'b0;
			busy_q <= 1'b1;
			busyCnt_q <= '0;
			genOe_q <= 1'b0;
			genCnt_q <= '0;
			genClk_q <= 1'b0;
			rdOe_q <= 1'b0;
			rdData_q <= '0;
			initLow_q <= 1'b1;
		end
		else
		begin
			phase_q <= phase_d;
			porCnt_q <= porCnt_d;
			wrPrev_q <= wrPrev_d;
			capData_q <= capData_d;
			pendData_q <= pendData_d;
			pendValid_q <= pendValid_d;
			hold_q <= hold_d;
			reqTog_q <= reqTog_d;
			busy_q <= busy_d;
			busyCnt_q <= busyCnt_d;
			genOe_q <= genOe_d;
			genCnt_q <= genCnt_d;
			genClk_q <= genClk_d;
			rdOe_q <= rdOe_d;
			rdData_q <= rdData_d;
			initLow_q <= initLow_d;
		end
	end

	assign readyBusy = !busy_q;
	assign dataOut = rdData_q;
	assign dataOe = rdOe_q;
	assign initOut = 1'b0;
	assign initOe = initLow_q;
	assign configClockOut = genClk_q;
	assign configClockOe = genOe_q;

	// ****************************************
	// configuration clock domain
	// ****************************************
	logic linkRstA_q, linkRst_q;
	logic reqS1_q, reqS2_q;
	logic reqSeen_d;
	logic [BW-1:0] shift_q, shift_d;
	logic [NW-1:0] bitCnt_q, bitCnt_d;
	logic linkIdle_d;
	logic loadNow;

	// next byte enters as the last bit of the previous leaves, or at once if the shifter is idle
	assign loadNow = reqS2_q != reqSeen_q && bitCnt_q <= NW'(1);

	always_comb
	begin
		reqSeen_d = reqSeen_q;
		shift_d = shift_q;
		bitCnt_d = bitCnt_q;
		if (loadNow)
		begin
			shift_d = hold_q;
			bitCnt_d = NW'(BW);
			reqSeen_d = reqS2_q;
		end
		else if (bitCnt_q != '0)
		begin
			shift_d = {shift_q[BW-2:0], 1'b0};
			bitCnt_d = bitCnt_q - NW'(1);
		end
		linkIdle_d = bitCnt_d == '0;
	end

	always_ff @(posedge configClk)
	begin
		linkRstA_q <= rst;
		linkRst_q <= linkRstA_q;
		reqS1_q <= reqTog_q;
		reqS2_q <= reqS1_q;
		if (linkRst_q)
		begin
			reqSeen_q <= 1'b0;
			shift_q <= '0;
			bitCnt_q <= '0;
			tick_q <= 1'b0;
			linkIdle_q <= 1'b1;
		end
		else
		begin
			reqSeen_q <= reqSeen_d;
			shift_q <= shift_d;
			bitCnt_q <= bitCnt_d;
			tick_q <= !tick_q;
			linkIdle_q <= linkIdle_d;
		end
	end

	assign serialOut = shift_q[BW-1];
	assign serialValid = bitCnt_q != '0;

	// ****************************************
	// checks
	// ****************************************
	logic emptyAtCommit_q;
	logic [GW:0] gap_q;
	always_ff @(posedge mclk)
	begin
		if (rst || commit)
			emptyAtCommit_q <= !rst && idleS2_q && !reqBusy && !bufOutValid;
		if (rst || !genOe_q || genClk_q != genClk_d)
			gap_q <= '0;
		else
			gap_q <= gap_q + (GW + 1)'(1);
	end

	AST_BUSY_MIN: assert property (@(posedge mclk) disable iff (rst)
		$fell(busy_q) && phase_q == acl_pkg::PH_LOAD
		|-> $past(busyCnt_q) >= CW'(acl_pkg::BUSY_MIN_PERIODS))
		else $error("busy released too early");
	AST_BUSY_MAX: assert property (@(posedge mclk) disable iff (rst)
		busy_q && phase_q == acl_pkg::PH_LOAD |-> busyCnt_q <= CW'(acl_pkg::BUSY_MAX_PERIODS))
		else $error("busy held too long");
	AST_BUSY_WHEN_FULL: assert property (@(posedge mclk) disable iff (rst)
		(pendValid_q || bufOutValid || reqBusy) |-> !readyBusy)
		else $error("ready shown while converter holds a byte");
	AST_SHORT_WHEN_EMPTY: assert property (@(posedge mclk) disable iff (rst)
		$fell(busy_q) && emptyAtCommit_q
		|-> $past(busyCnt_q) <= CW'(acl_pkg::BUSY_MIN_PERIODS + acl_pkg::BUSY_SHORT_SLACK))
		else $error("empty converter did not give shortest busy");
	AST_LONG_WAITS_SHIFT: assert property (@(posedge mclk) disable iff (rst)
		busy_q && reqBusy |=> busy_q)
		else $error("busy dropped before shifter took waiting byte");
	AST_NO_RELOAD_MIDBYTE: assert property (@(posedge configClk) disable iff (linkRst_q)
		bitCnt_q > NW'(1) |=> bitCnt_q == $past(bitCnt_q) - NW'(1))
		else $error("byte reloaded before previous finished");
	AST_INIT_ONLY_LOW: assert property (@(posedge mclk) disable iff (rst)
		(initOe |-> !initOut) and (phase_q == acl_pkg::PH_LOAD |-> !initOe))
		else $error("memory-clear flag driven high or late");
	AST_CONFIG_CLOCK_HALF: assert property (@(posedge mclk) disable iff (rst)
		genOe_q && $past(genOe_q) && genClk_q != genClk_d
		|-> gap_q + (GW + 1)'(1) >= (GW + 1)'(acl_pkg::CONFIG_CLOCK_FAST_HALF)
		&& gap_q < (GW + 1)'(acl_pkg::CONFIG_CLOCK_SLOW_HALF))
		else $error("generated clock half period out of range");
	AST_SHIFT_ONE_BIT: assert property (@(posedge configClk) disable iff (linkRst_q)
		bitCnt_q > NW'(1) |=> shift_q == {$past(shift_q[BW-2:0]), 1'b0})
		else $error("shifter moved other than one bit");
endmodule

// ### verification/acl_host_model.sv
`timescale 1ns/1ps
module acl_host_model #(
	parameter int CfgPeriodCycles = 34
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic readyBusy,
	input wire logic initIn,
	input wire logic [acl_pkg::BYTE_BITS-1:0] dataOut,
	input wire logic dataOe,
	output logic writeStrobeN,
	output logic readStrobeN,
	output logic chipSelectLowN,
	output logic chipSelectHigh,
	output logic [acl_pkg::BYTE_BITS-1:0] hostData
);
	bit firstDone = 1'b0;
	initial
	begin
		writeStrobeN = 1'b1;
		readStrobeN = 1'b1;
		chipSelectLowN = 1'b1;
		chipSelectHigh = 1'b0;
		hostData = 8'h5A;
	end
	// no ready is awaited before the first byte after reset
	always @(posedge mclk)
		if (rst)
			firstDone = 1'b0;
	// ****************************************
	// host bus cycles
	// ****************************************
	task automatic writeByte(input logic [7:0] b, output bit ok);
		int n;
		int hi;
		n = 0;
		while (initIn !== 1'b1 && n < 5000)
		begin
			@(posedge mclk);
			n++;
		end
		ok = n < 5000;
		@(posedge mclk);
		chipSelectLowN <= 1'b0;
		chipSelectHigh <= 1'b1;
		writeStrobeN <= 1'b0;
		hostData <= b;
		repeat (30) @(posedge mclk);
		n = 0;
		hi = 0;
		while (firstDone && hi < CfgPeriodCycles && n < 4000)
		begin
			@(posedge mclk);
			hi = (readyBusy === 1'b1) ? hi + 1 : 0;
			n++;
		end
		ok = ok && n < 4000;
		writeStrobeN <= 1'b1;
		chipSelectLowN <= 1'b1;
		chipSelectHigh <= 1'b0;
		hostData <= ~b;
		repeat (4) @(posedge mclk);
		n = 0;
		while (readyBusy !== 1'b0 && n < 16)
		begin
			@(posedge mclk);
			n++;
		end
		ok = ok && n < 16;
		firstDone = 1'b1;
	endtask
	task automatic readStatus(output logic oe, output logic [7:0] d);
		@(posedge mclk);
		chipSelectLowN <= 1'b0;
		chipSelectHigh <= 1'b1;
		readStrobeN <= 1'b0;
		repeat (6) @(posedge mclk);
		oe = dataOe;
		d = dataOut;
		readStrobeN <= 1'b1;
		chipSelectLowN <= 1'b1;
		chipSelectHigh <= 1'b0;
	endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int PorHigh = 20;
	localparam int PorLow = 40;
	localparam int ShortNs = (acl_pkg::BUSY_MIN_PERIODS + acl_pkg::BUSY_SHORT_SLACK + 1) * 125;
	logic mclk, rst, configClk, writeStrobeN, readStrobeN, chipSelectLowN, chipSelectHigh;
	logic [7:0] hostData, dataWire, dataOut, rdData, shiftReg;
	logic dataOe, readyBusy, initIn, initOut, initOe, chainHold, rdOe;
	logic masterMode, fastRate, modePinZero, configClockOut, configClockOe, serialOut, serialValid;
	int errTotal = 0;
	int checks = 0;
	int seed = 46277;
	int pace = 0;
	int busyPace = 0;
	int busyCnt = 0;
	int bitCnt = 0;
	bit armed = 1'b0;
	logic [7:0] expQ[$];
	assign dataWire = dataOe ? dataOut : hostData;
	assign initIn = !(initOe || chainHold);
	acl_async_loader #(.PorHighCycles(PorHigh), .PorLowCycles(PorLow)) acl_async_loader_i (
		.mclk(mclk), .rst(rst), .configClk(configClk), .writeStrobeN(writeStrobeN),
		.readStrobeN(readStrobeN), .chipSelectLowN(chipSelectLowN),
		.chipSelectHigh(chipSelectHigh), .dataIn(dataWire), .dataOut(dataOut), .dataOe(dataOe),
		.readyBusy(readyBusy), .initIn(initIn), .initOut(initOut), .initOe(initOe),
		.masterMode(masterMode), .fastRate(fastRate), .modePinZero(modePinZero),
		.configClockOut(configClockOut), .configClockOe(configClockOe), .serialOut(serialOut),
		.serialValid(serialValid));
	acl_host_model acl_host_model_i (.mclk(mclk), .rst(rst), .readyBusy(readyBusy),
		.initIn(initIn), .dataOut(dataOut), .dataOe(dataOe), .writeStrobeN(writeStrobeN),
		.readStrobeN(readStrobeN), .chipSelectLowN(chipSelectLowN),
		.chipSelectHigh(chipSelectHigh), .hostData(hostData));
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		configClk = 1'b0;
		#4017;
		forever #62.5 configClk = ~configClk;
	end
	// ****************************************
	// checking
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic printVerdict();
		if (errTotal == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(negedge mclk)
	begin
		if (initOe === 1'b1)
			check("clear pin level", initOut, 1'b0);
		if (rst)
		begin
			armed = 1'b0;
			busyCnt = 0;
		end
		else if (readyBusy === 1'b0)
		begin
			if (busyCnt == 0)
				busyPace = pace;
			busyCnt++;
		end
		else
		begin
			if (armed && busyCnt > 0)
			begin
				check("busy min", busyCnt * 4 >= 250, 1'b1);
				check("busy max", busyCnt * 4 <= 1125, 1'b1);
				if (busyPace == 1)
					check("busy short", busyCnt * 4 <= ShortNs, 1'b1);
				if (busyPace == 2)
					check("busy long", busyCnt * 4 > ShortNs, 1'b1);
			end
			armed = 1'b1;
			busyCnt = 0;
		end
	end
	always @(negedge configClk)
	begin
		if (rst)
			bitCnt = 0;
		else if (serialValid === 1'b1)
		begin
			shiftReg = {shiftReg[6:0], serialOut};
			bitCnt++;
			if (bitCnt == 8)
			begin
				bitCnt = 0;
				if (expQ.size() == 0)
					check("extra byte", 1'b1, 1'b0);
				else
					check("serial byte", shiftReg, expQ.pop_front());
			end
		end
		else if (bitCnt != 0)
			check("gap inside byte", bitCnt, 0);
	end
	// ****************************************
	// stimulus
	// ****************************************
	task automatic sendByte(input int p);
		logic [7:0] b;
		bit ok;
		pace = p;
		b = $random(seed);
		expQ.push_back(b);
		acl_host_model_i.writeByte(b, ok);
		check("host handshake", ok, 1'b1);
	endtask
	task automatic clearLen(input int exp);
		int n;
		n = 0;
		@(posedge mclk);
		rst <= 1'b0;
		while (initOe !== 1'b0 && n < 1000)
		begin
			@(posedge mclk);
			n++;
		end
		check("clear length", n >= exp && n <= exp + 4, 1'b1);
		repeat (20) @(posedge mclk);
		chainHold <= 1'b0;
	endtask
	task automatic waitGen(input logic v, inout int n);
		while (configClockOut !== v && n < 3000)
		begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic genPeriod(input int lo, input int hi);
		int n;
		n = 0;
		waitGen(1'b0, n);
		waitGen(1'b1, n);
		n = 0;
		waitGen(1'b0, n);
		waitGen(1'b1, n);
		check("generator period", n * 4 >= lo && n * 4 <= hi, 1'b1);
		check("generator drive", configClockOe, 1'b1);
	endtask
	initial
	begin
		repeat (60000) @(posedge mclk);
		errTotal++;
		printVerdict();
	end
	initial
	begin
		rst = 1'b1;
		masterMode = 1'b0;
		fastRate = 1'b0;
		modePinZero = 1'b0;
		chainHold = 1'b1;
		repeat (8) @(posedge configClk);
		check("busy in reset", readyBusy, 1'b0);
		check("clear in reset", initOe, 1'b1);
		clearLen(PorLow);
		for (int i = 0; i < 3; i++)
		begin
			sendByte(1);
			repeat (500) @(posedge mclk);
		end
		sendByte(1);
		for (int i = 0; i < 5; i++)
			sendByte(2);
		repeat (600) @(posedge mclk);
		check("data drive idle", dataOe, 1'b0);
		acl_host_model_i.readStatus(rdOe, rdData);
		check("status drive", rdOe, 1'b1);
		check("status ready", rdData, 8'h80);
		check("bytes left", expQ.size(), 0);
		@(posedge mclk);
		modePinZero <= 1'b1;
		rst <= 1'b1;
		chainHold <= 1'b1;
		repeat (4) @(posedge configClk);
		clearLen(PorHigh);
		sendByte(0);
		repeat (600) @(posedge mclk);
		@(posedge mclk);
		masterMode <= 1'b1;
		fastRate <= 1'b1;
		repeat (50) @(posedge mclk);
		genPeriod(acl_pkg::CONFIG_CLOCK_FAST_MIN_NS, acl_pkg::CONFIG_CLOCK_FAST_MAX_NS);
		fastRate <= 1'b0;
		repeat (400) @(posedge mclk);
		genPeriod(acl_pkg::CONFIG_CLOCK_SLOW_MIN_NS, acl_pkg::CONFIG_CLOCK_SLOW_MAX_NS);
		check("bytes left", expQ.size(), 0);
		printVerdict();
	end
endmodule
